// *** rtl/ltm_pkg.sv ***
// Constants, field layouts and carrier types for the dual timebase capture timer
package ltm_pkg;

    // ---------------------------------------------------------------
    // Register indices, byte address is four times the index
    // ---------------------------------------------------------------
    localparam logic [5:0] IDX_CSR2 = 6'h08;
    localparam logic [5:0] IDX_RELOAD = 6'h09;
    localparam logic [5:0] IDX_CNT2 = 6'h0a;
    localparam logic [5:0] IDX_CSR1 = 6'h0b;
    localparam logic [5:0] IDX_CAP = 6'h0c;

    // ---------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------
    localparam int unsigned CSR2_IE_BIT = 1;
    localparam int unsigned CSR2_FLAG_BIT = 0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [23:0] PAD_ZERO = 24'h000000;

    // Flag vector positions
    localparam int unsigned FL_TB2 = 0;
    localparam int unsigned FL_CAP = 1;
    localparam int unsigned FL_TB1 = 2;
    localparam int unsigned NFLAGS = 3;

    // ---------------------------------------------------------------
    // Timing counts
    // ---------------------------------------------------------------
    localparam logic [4:0] PRESC_LAST = 5'h1f;
    localparam logic [4:0] PRESC_ZERO = 5'h00;
    localparam logic [7:0] C1_LAST = 8'hf9;
    localparam logic [7:0] C2_LAST = 8'hff;

    // ---------------------------------------------------------------
    // Bus constants
    // ---------------------------------------------------------------
    localparam logic [2:0] SIZE_WORD = 3'h2;

    typedef struct packed {
        logic capture_irq_enable;
        logic capture_flag;
        logic tb;
        logic first_timebase_irq_enable;
        logic first_timebase_flag;
        logic [2:0] rsvd;
    } ltm_csr1_t;

    typedef struct packed {
        logic wr;
        logic [5:0] idx;
    } ltm_pend_t;

endpackage

// *** rtl/ltm_timer.sv ***
// Dual timebase capture timer with AHB-Lite register slave
`timescale 1ns/10ps
module ltm_timer
    import ltm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic halt_mode,
    input wire logic capture_input_pin,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic irq
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic [4:0] presc_reg, presc_next;
    logic [7:0] c1_reg, c1_next;
    logic [7:0] c2_reg, c2_next;
    logic [7:0] reload_reg, reload_next;
    logic [7:0] cap_reg, cap_next;
    logic half_reg, half_next;
    logic pin_reg, pin_next;
    logic second_timebase_irq_enable_reg, second_timebase_irq_enable_next;
    logic capture_irq_enable_reg, capture_irq_enable_next;
    logic tb_reg, tb_next;
    logic first_timebase_irq_enable_reg, first_timebase_irq_enable_next;
    logic [NFLAGS-1:0] flag_reg, flag_next;
    logic [NFLAGS-1:0] flag_set, flag_clr, flag_en;
    ltm_pend_t pend_reg, pend_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic irq_reg, irq_next;
    logic hreadyout_reg;

    logic tick, c1_wrap, c2_wrap, pin_edge, take, rd;
    logic [5:0] ridx;
    logic [7:0] rd_byte;
    ltm_csr1_t csr1_view;

    // ---------------------------------------------------------------
    // Timebase and capture
    // ---------------------------------------------------------------
    always_comb begin
        tick = ~halt_mode & (presc_reg == PRESC_LAST);
        c1_wrap = tick & (c1_reg == C1_LAST);
        c2_wrap = tick & (c2_reg == C2_LAST);
        pin_edge = pin_reg ^ capture_input_pin;
        pin_next = capture_input_pin;

        presc_next = presc_reg;
        if (~halt_mode) begin
            presc_next = presc_reg + 5'h01;
        end

        c1_next = c1_reg;
        half_next = half_reg;
        if (c1_wrap) begin
            c1_next = BYTE_ZERO;
            half_next = ~half_reg;
        end else if (tick) begin
            c1_next = c1_reg + 8'h01;
        end

        c2_next = c2_reg;
        if (c2_wrap) begin
            c2_next = reload_reg;
        end else if (tick) begin
            c2_next = c2_reg + 8'h01;
        end

        cap_next = cap_reg;
        if (pin_edge & ~flag_reg[FL_CAP]) begin
            cap_next = c1_reg;
        end
    end

    // ---------------------------------------------------------------
    // Bus decode and register writes
    // ---------------------------------------------------------------
    always_comb begin
        take = hsel & htrans[1] & hready & (hsize == SIZE_WORD);
        rd = take & ~hwrite;
        ridx = haddr[7:2];
        pend_next.wr = take & hwrite;
        pend_next.idx = ridx;

        reload_next = reload_reg;
        second_timebase_irq_enable_next = second_timebase_irq_enable_reg;
        capture_irq_enable_next = capture_irq_enable_reg;
        tb_next = tb_reg;
        first_timebase_irq_enable_next = first_timebase_irq_enable_reg;
        if (pend_reg.wr) begin
            case (pend_reg.idx)
                IDX_CSR2: begin
                    second_timebase_irq_enable_next = hwdata[CSR2_IE_BIT];
                end
                IDX_RELOAD: begin
                    reload_next = hwdata[7:0];
                end
                IDX_CSR1: begin
                    csr1_view = ltm_csr1_t'(hwdata[7:0]);
                    capture_irq_enable_next = csr1_view.capture_irq_enable;
                    tb_next = csr1_view.tb;
                    first_timebase_irq_enable_next = csr1_view.first_timebase_irq_enable;
                end
                default: begin
                    reload_next = reload_reg;
                end
            endcase
        end

        csr1_view = '0;
        csr1_view.capture_irq_enable = capture_irq_enable_reg;
        csr1_view.capture_flag = flag_reg[FL_CAP];
        csr1_view.tb = tb_reg;
        csr1_view.first_timebase_irq_enable = first_timebase_irq_enable_reg;
        csr1_view.first_timebase_flag = flag_reg[FL_TB1];

        case (ridx)
            IDX_CSR2: begin
                rd_byte = BYTE_ZERO;
                rd_byte[CSR2_IE_BIT] = second_timebase_irq_enable_reg;
                rd_byte[CSR2_FLAG_BIT] = flag_reg[FL_TB2];
            end
            IDX_RELOAD: rd_byte = reload_reg;
            IDX_CNT2: rd_byte = c2_reg;
            IDX_CSR1: rd_byte = csr1_view;
            IDX_CAP: rd_byte = cap_reg;
            default: rd_byte = BYTE_ZERO;
        endcase
        hrdata_next = rd ? {PAD_ZERO, rd_byte} : hrdata_reg;
    end

    // ---------------------------------------------------------------
    // Flags and interrupt
    // ---------------------------------------------------------------
    always_comb begin
        flag_set[FL_TB2] = c2_wrap;
        flag_clr[FL_TB2] = rd & (ridx == IDX_CSR2);
        flag_set[FL_CAP] = pin_edge & ~flag_reg[FL_CAP];
        flag_clr[FL_CAP] = rd & (ridx == IDX_CAP);
        // counter 1 flag, doubled period skips every other wrap
        flag_set[FL_TB1] = c1_wrap & (half_reg | ~tb_reg);
        flag_clr[FL_TB1] = rd & (ridx == IDX_CSR1);
        flag_en[FL_TB2] = second_timebase_irq_enable_reg;
        flag_en[FL_CAP] = capture_irq_enable_reg;
        flag_en[FL_TB1] = first_timebase_irq_enable_reg;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NFLAGS; gi++) begin : g_flag
            assign flag_next[gi] = flag_set[gi] | (flag_reg[gi] & ~flag_clr[gi]);
        end
    endgenerate

    assign irq_next = |(flag_next & flag_en);

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    // Clock enable low freezes every bit except hreadyout_reg; bus should idle meanwhile
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_reg <= PRESC_ZERO;
            c1_reg <= BYTE_ZERO;
            c2_reg <= BYTE_ZERO;
            reload_reg <= BYTE_ZERO;
            cap_reg <= BYTE_ZERO;
            half_reg <= 1'b0;
            pin_reg <= 1'b0;
            second_timebase_irq_enable_reg <= 1'b0;
            capture_irq_enable_reg <= 1'b0;
            tb_reg <= 1'b0;
            first_timebase_irq_enable_reg <= 1'b0;
            // Capture flag has no defined reset value; cleared for determinism
            flag_reg <= '0;
            pend_reg <= '0;
            hrdata_reg <= '0;
            irq_reg <= 1'b0;
        end else if (ce) begin
            presc_reg <= presc_next;
            c1_reg <= c1_next;
            c2_reg <= c2_next;
            reload_reg <= reload_next;
            cap_reg <= cap_next;
            half_reg <= half_next;
            pin_reg <= pin_next;
            second_timebase_irq_enable_reg <= second_timebase_irq_enable_next;
            capture_irq_enable_reg <= capture_irq_enable_next;
            tb_reg <= tb_next;
            first_timebase_irq_enable_reg <= first_timebase_irq_enable_next;
            flag_reg <= flag_next;
            pend_reg <= pend_next;
            hrdata_reg <= hrdata_next;
            irq_reg <= irq_next;
        end
    end

    // Zero wait states: ready rises at the first edge after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_reg <= 1'b0;
        end else begin
            hreadyout_reg <= 1'b1;
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hrdata = hrdata_reg;
    assign hresp = 1'b0;
    assign irq = irq_reg;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_c2_wrap;
        ce && tick && (c2_reg == C2_LAST);
    endsequence

    sequence s_cap_read_only;
        ce && rd && (ridx == IDX_CAP) && !pin_edge;
    endsequence

    sequence s_cap_take;
        ce && pin_edge && !flag_reg[FL_CAP];
    endsequence

    a_c2_reload_load: assert property (s_c2_wrap |=> c2_reg == $past(reload_reg))
        else $error("counter 2 did not take the reload value");

    a_tb2_flag_set: assert property (s_c2_wrap |=> flag_reg[FL_TB2])
        else $error("counter 2 overflow flag not set");

    a_c1_wrap_zero: assert property (ce && tick && c1_reg == C1_LAST |=> c1_reg == BYTE_ZERO)
        else $error("counter 1 did not wrap to zero");

    a_halt_freezes: assert property (ce && halt_mode |=> $stable(c1_reg) && $stable(c2_reg))
        else $error("counters moved in halt");

    a_cap_inhibited: assert property (flag_reg[FL_CAP] |=> $stable(cap_reg))
        else $error("capture changed while flag set");

    a_cap_read_clear: assert property (s_cap_read_only |=> !flag_reg[FL_CAP])
        else $error("capture read did not clear flag");

    a_set_beats_clear: assert property (
        ce && flag_clr[FL_TB2] && flag_set[FL_TB2] |=> flag_reg[FL_TB2])
        else $error("flag event lost to clearing read");

    a_irq_tb1_masked: assert property (
        ce && !first_timebase_irq_enable_reg && !capture_irq_enable_reg && !second_timebase_irq_enable_reg && !first_timebase_irq_enable_next
        && !capture_irq_enable_next && !second_timebase_irq_enable_next |=> !irq)
        else $error("interrupt raised with all enables clear");

    a_cnt_write_ignored: assert property (
        ce && pend_reg.wr && pend_reg.idx == IDX_CNT2 && !tick |=> $stable(c2_reg))
        else $error("write changed counter 2");

    a_tb2_read_clear: assert property (
        ce && flag_clr[FL_TB2] && !flag_set[FL_TB2] |=> !flag_reg[FL_TB2])
        else $error("status read did not clear counter 2 flag");

    a_tb1_read_clear: assert property (
        ce && flag_clr[FL_TB1] && !flag_set[FL_TB1] |=> !flag_reg[FL_TB1])
        else $error("status read did not clear counter 1 flag");

    a_tb2_irq_raise: assert property (ce && flag_next[FL_TB2] && second_timebase_irq_enable_reg |=> irq)
        else $error("enabled counter 2 flag raised no interrupt");

    a_cap_irq_raise: assert property (ce && flag_next[FL_CAP] && capture_irq_enable_reg |=> irq)
        else $error("enabled capture flag raised no interrupt");

    a_tb1_irq_raise: assert property (ce && flag_next[FL_TB1] && first_timebase_irq_enable_reg |=> irq)
        else $error("enabled counter 1 flag raised no interrupt");

    a_cap_take_count: assert property (
        s_cap_take |=> cap_reg == $past(c1_reg) && flag_reg[FL_CAP])
        else $error("edge did not capture counter 1");

    a_c2_tick_step: assert property (
        ce && tick && (c2_reg != C2_LAST) |=> c2_reg == $past(c2_reg) + 8'h01)
        else $error("counter 2 did not step by one");

endmodule // ltm_timer

// *** tb/ltm_edge_src.sv ***
// Partner model: external edge source driving the capture input pin
`timescale 1ns/10ps
module ltm_edge_src (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic flip,
    output logic capture_input_pin
);
    // one edge per flip
    // Synchronous edges only, so no metastability handling is modelled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capture_input_pin <= 1'b0;
        end else if (flip) begin
            capture_input_pin <= ~capture_input_pin;
        end
    end
endmodule // ltm_edge_src

// *** tb/tb_top.sv ***
// Self-checking testbench for the dual timebase capture timer
`timescale 1ns/10ps
module tb_top;
    import ltm_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, halt_mode = 1'b0, flip = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic hreadyout, hresp, irq, pin;
    logic ce = 1'b1;
    int err_total = 0, total_checks = 0, cyc = 0, t0, t1, t2;

    // ------------------------------------------------------------
    // Clock, partner and design
    // ------------------------------------------------------------
    initial begin
        forever #10 hclk = ~hclk;
    end
    always @(posedge hclk) cyc <= cyc + 1;
    ltm_edge_src u_src (.hclk(hclk), .hresetn(hresetn), .flip(flip), .capture_input_pin(pin));
    ltm_timer DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .halt_mode(halt_mode),
        .capture_input_pin(pin), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Entered just after a rising edge; waits on hready, never on a fixed count
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= SIZE_WORD;
        haddr <= {24'h0, idx, 2'h0};
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        // A wait that runs out is a failure, not a silent retry
        if (hreadyout !== 1'b1) err_total++;
        rd = hrdata;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d, v);
    endtask
    task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0, v);
        chk(v, exp);
    endtask
    // Level irq sampled on falling edges to stay clear of the register update
    task automatic wait_irq(output int t);
        int n;
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (irq !== 1'b1 && n < 20000);
        if (irq !== 1'b1) err_total++;
        t = cyc;
        @(posedge hclk);
    endtask
    task automatic toggle;
        flip <= 1'b1;
        @(posedge hclk);
        flip <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (95000) @(posedge hclk);
        err_total++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(IDX_CAP, 32'h0);
        rdc(IDX_CSR2, 32'h0);
        rdc(IDX_RELOAD, 32'h0);
        rdc(IDX_CNT2, 32'h0);
        rdc(IDX_CSR1, 32'h0);
        rdc(6'h0d, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        wr(IDX_RELOAD, 32'hfe);
        rdc(IDX_RELOAD, 32'hfe);
        wr(IDX_CSR2, 32'h2);
        wait_irq(t0);
        rdc(IDX_CNT2, 32'hfe);
        wr(IDX_CNT2, 32'h0);
        rdc(IDX_CNT2, 32'hfe);
        rdc(IDX_CSR2, 32'h3);
        chk({31'h0, irq}, 32'h0);
        rdc(IDX_CSR2, 32'h2);
        // Clearing the enable also tries to set the flag by writing it
        wr(IDX_CSR2, 32'h1);
        repeat (80) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        rdc(IDX_CSR2, 32'h1);
        wr(IDX_CSR1, 32'h10);
        // Counter 1 has already wrapped once, so its flag is stale here
        rdc(IDX_CSR1, 32'h18);
        wait_irq(t0);
        rdc(IDX_CSR1, 32'h18);
        wait_irq(t1);
        rdc(IDX_CSR1, 32'h18);
        chk(t1 - t0, 32'd8000);
        repeat (100) @(posedge hclk);
        halt_mode <= 1'b1;
        repeat (200) @(posedge hclk);
        halt_mode <= 1'b0;
        // Clock enable low freezes the timebase just as halt does
        ce <= 1'b0;
        repeat (100) @(posedge hclk);
        ce <= 1'b1;
        wait_irq(t2);
        chk(t2 - t1, 32'd8300);
        rdc(IDX_CSR1, 32'h18);
        wr(IDX_CSR1, 32'hd0);
        while (cyc < t2 + 160) @(posedge hclk);
        toggle();
        repeat (3) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        rdc(IDX_CSR1, 32'hd0);
        rdc(IDX_CSR1, 32'hd0);
        repeat (64) @(posedge hclk);
        toggle();
        rdc(IDX_CAP, 32'h5);
        rdc(IDX_CSR1, 32'h90);
        chk({31'h0, irq}, 32'h0);
        wr(IDX_CSR1, 32'h30);
        wait_irq(t0);
        rdc(IDX_CSR1, 32'h38);
        wait_irq(t0);
        rdc(IDX_CSR1, 32'h38);
        wait_irq(t1);
        chk(t1 - t0, 32'd16000);
        complete_run();
    end
endmodule // tb_top
